// ==== ebpt_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the period timer block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Offsets are word indices; byte address is four times the index
`ifndef EBPT_DEFS_SVH
`define EBPT_DEFS_SVH

`define EBPT_IDX_CTRL4 12'hf76
`define EBPT_IDX_CTRL6 12'hf1e
`define EBPT_IDX_CTRL8 12'hf1b
`define EBPT_IDX_COUNT4 12'h000
`define EBPT_IDX_COUNT6 12'h001
`define EBPT_IDX_COUNT8 12'h002
`define EBPT_IDX_PERIOD4 12'h004
`define EBPT_IDX_PERIOD6 12'h005
`define EBPT_IDX_PERIOD8 12'h006
`define EBPT_IDX_IRQ_STATUS 12'h008
`define EBPT_IDX_IRQ_ENABLE 12'h009
`define EBPT_IDX_IRQ_CLEAR 12'h00a

`define EBPT_CTRL_PRESC_LSB 0
`define EBPT_CTRL_RUN_BIT 2
`define EBPT_CTRL_POSTSC_LSB 3
`define EBPT_CTRL_WMASK 8'h7f

`define EBPT_COUNT_RST 8'h00
`define EBPT_PERIOD_RST 8'hff
`define EBPT_CTRL_RST 8'h00

`define EBPT_ICYC_DIV 4
`define EBPT_PRESC_MAX_1 4'h0
`define EBPT_PRESC_MAX_4 4'h3
`define EBPT_PRESC_MAX_16 4'hf

`define EBPT_RESP_OKAY 2'h0
`define EBPT_RESP_SLVERR 2'h2

`endif

// ==== ebpt_pkg.sv ====
// Purpose: Types shared by the period timer block
// Assumes: Constants come from ebpt_defs.svh
// Notes: Control layout mirrors the control register bits 7..0
package ebpt_pkg;

  typedef struct packed {
    logic unused7;
    logic [3:0] postscale_select;
    logic timer_run_bit;
    logic [1:0] prescale_select;
  } ebpt_ctrl_s;

  typedef enum logic [2:0] {
    EBPT_REG_NONE,
    EBPT_REG_CTRL,
    EBPT_REG_COUNT,
    EBPT_REG_PERIOD,
    EBPT_REG_IRQ_STATUS,
    EBPT_REG_IRQ_ENABLE,
    EBPT_REG_IRQ_CLEAR
  } ebpt_reg_e;

  typedef struct packed {
    ebpt_reg_e kind;
    logic [1:0] unit;
  } ebpt_sel_s;

  typedef struct packed {
    logic [13:0] addr;
    logic [2:0] prot;
  } ebpt_addr_s;

endpackage

// ==== ebpt_timer.sv ====
// Purpose: Three 8-bit period timers with prescaler, postscaler, interrupt and PWM time-base match
// Assumes: aclk is the oscillator; the instruction cycle is one aclk in four
// Notes: AXI4-Lite slave, one write and one read in flight, answers a write two cycles after both halves, a read one cycle after
//
// Summary of operation
// - Readable, writable 8-bit count and period registers
// - Count up to period, then back to zero
// - Period register resets to all ones
// - Count clocked by instruction cycle through prescaler
// - Prescale field: 00 /1, 01 /4, 1x /16
// - Postscale field counts 1 to 16 matches
// - Postscaler completion sets sticky interrupt flag
// - Interrupt forwarded only while enable bit set
// - Count or control write clears both scalers
// - Control write leaves count unchanged
// - Count clears to zero on reset
// - Run bit clear stops the timer
// - Pre-postscaler match drives PWM time base and gate pulse
// - Return to zero pulses the gate selector
//
// Our own choice: the AXI4-Lite slave port.
`include "ebpt_defs.svh"
`timescale 1ns/10ps
module ebpt_timer #(
  parameter int NUM_TIMERS = 3,
  parameter int ADDR_W = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [NUM_TIMERS-1:0] pwm_time_base_match,
  output logic [NUM_TIMERS-1:0] gate_match_pulse
);
  import ebpt_pkg::*;

  if (NUM_TIMERS < 1 || NUM_TIMERS > 3) begin : g_bad_num
    $error("NUM_TIMERS must be 1 to 3");
  end
  if (ADDR_W != 14) begin : g_bad_addr
    $error("ADDR_W must be 14");
  end

  function automatic ebpt_sel_s reg_decode(input logic [ADDR_W-1:0] byte_addr);
    ebpt_sel_s s;
    logic [11:0] idx;
    s = '{EBPT_REG_NONE, 2'd0};
    idx = byte_addr[ADDR_W-1:2];
    case (idx)
      `EBPT_IDX_CTRL4: s = '{EBPT_REG_CTRL, 2'd0};
      `EBPT_IDX_CTRL6: s = '{EBPT_REG_CTRL, 2'd1};
      `EBPT_IDX_CTRL8: s = '{EBPT_REG_CTRL, 2'd2};
      `EBPT_IDX_COUNT4: s = '{EBPT_REG_COUNT, 2'd0};
      `EBPT_IDX_COUNT6: s = '{EBPT_REG_COUNT, 2'd1};
      `EBPT_IDX_COUNT8: s = '{EBPT_REG_COUNT, 2'd2};
      `EBPT_IDX_PERIOD4: s = '{EBPT_REG_PERIOD, 2'd0};
      `EBPT_IDX_PERIOD6: s = '{EBPT_REG_PERIOD, 2'd1};
      `EBPT_IDX_PERIOD8: s = '{EBPT_REG_PERIOD, 2'd2};
      `EBPT_IDX_IRQ_STATUS: s = '{EBPT_REG_IRQ_STATUS, 2'd0};
      `EBPT_IDX_IRQ_ENABLE: s = '{EBPT_REG_IRQ_ENABLE, 2'd0};
      `EBPT_IDX_IRQ_CLEAR: s = '{EBPT_REG_IRQ_CLEAR, 2'd0};
      default: s = '{EBPT_REG_NONE, 2'd0};
    endcase
    // Units beyond the built count answer as unmapped
    if (32'(s.unit) >= NUM_TIMERS) begin
      s = '{EBPT_REG_NONE, 2'd0};
    end
    return s;
  endfunction

  function automatic logic [3:0] presc_max(input logic [1:0] sel);
    logic [3:0] m;
    m = `EBPT_PRESC_MAX_16;
    if (sel == 2'b00) begin
      m = `EBPT_PRESC_MAX_1;
    end else if (sel == 2'b01) begin
      m = `EBPT_PRESC_MAX_4;
    end
    return m;
  endfunction

  // Write channel: address and data caught in either order
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic awready_r;
  logic wready_r;
  wire aw_hs = s_axi_awvalid & awready_r;
  wire w_hs = s_axi_wvalid & wready_r;
  wire do_write = aw_held_r & w_held_r & ~bvalid_r;
  wire aw_held_nxt = aw_hs | (aw_held_r & ~do_write);
  wire w_held_nxt = w_hs | (w_held_r & ~do_write);
  wire bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
  wire awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
  wire wready_nxt = ~w_held_nxt & ~bvalid_nxt;
  ebpt_sel_s wsel;
  assign wsel = reg_decode(aw_addr_r);
  // Data sits in byte lane 0; a write without that lane changes nothing
  wire wr_lane0 = do_write & w_strb_r[0];
  wire [1:0] bresp_nxt = (wsel.kind == EBPT_REG_NONE) ? `EBPT_RESP_SLVERR : `EBPT_RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
    end else begin
      w_held_r <= w_held_nxt;
    end
  end

  // Response stands until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
    end else begin
      bvalid_r <= bvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
    end else begin
      wready_r <= wready_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= '0;
    end else if (aw_hs) begin
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (w_hs) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_r <= `EBPT_RESP_OKAY;
    end else if (do_write) begin
      bresp_r <= bresp_nxt;
    end
  end

  // Instruction cycle: one aclk in four
  logic [1:0] icyc_div_r;
  wire icyc = (icyc_div_r == 2'(`EBPT_ICYC_DIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icyc_div_r <= 2'h0;
    end else begin
      icyc_div_r <= icyc_div_r + 2'h1;
    end
  end

  // Interrupt registers, one bit per timer
  logic [NUM_TIMERS-1:0] irq_status_r;
  logic [NUM_TIMERS-1:0] irq_enable_r;
  logic irq_r;
  logic [NUM_TIMERS-1:0] post_done;
  wire wr_enable = wr_lane0 & (wsel.kind == EBPT_REG_IRQ_ENABLE);
  wire wr_clear = wr_lane0 & (wsel.kind == EBPT_REG_IRQ_CLEAR);
  wire [NUM_TIMERS-1:0] clr_bits = wr_clear ? w_data_r[NUM_TIMERS-1:0] : '0;
  // Set wins over a clear in the same cycle
  wire [NUM_TIMERS-1:0] irq_status_nxt = (irq_status_r & ~clr_bits) | post_done;
  wire [NUM_TIMERS-1:0] irq_enable_nxt = wr_enable ? w_data_r[NUM_TIMERS-1:0] : irq_enable_r;
  wire irq_nxt = |(irq_status_nxt & irq_enable_nxt);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_r <= '0;
    end else begin
      irq_enable_r <= irq_enable_nxt;
    end
  end

  // Registered so the pin never glitches on decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Per-timer datapath
  ebpt_ctrl_s ctrl_r [NUM_TIMERS];
  logic [7:0] count_r [NUM_TIMERS];
  logic [7:0] period_r [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] match_r;

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    logic [3:0] pre_r;
    logic [3:0] post_r;
    wire unit_hit = (32'(wsel.unit) == i);
    wire wr_ctrl = wr_lane0 & unit_hit & (wsel.kind == EBPT_REG_CTRL);
    wire wr_count = wr_lane0 & unit_hit & (wsel.kind == EBPT_REG_COUNT);
    wire wr_period = wr_lane0 & unit_hit & (wsel.kind == EBPT_REG_PERIOD);
    wire scal_clr = wr_count | wr_ctrl;
    wire [3:0] pmax = presc_max(ctrl_r[i].prescale_select);
    wire run_tick = ctrl_r[i].timer_run_bit & icyc;
    wire pre_wrap = (pre_r == pmax);
    wire inc = run_tick & pre_wrap;
    // Software write to the count takes precedence over a match
    wire match_evt = inc & (count_r[i] == period_r[i]) & ~wr_count;
    wire [3:0] pre_step = pre_wrap ? 4'h0 : pre_r + 4'h1;
    wire [3:0] pre_nxt = scal_clr ? 4'h0 : (run_tick ? pre_step : pre_r);
    wire post_hit = (post_r == ctrl_r[i].postscale_select);
    wire [3:0] post_step = post_hit ? 4'h0 : post_r + 4'h1;
    wire [3:0] post_nxt = scal_clr ? 4'h0 : (match_evt ? post_step : post_r);
    wire [7:0] count_nxt = wr_count ? w_data_r[7:0] :
                           (match_evt ? `EBPT_COUNT_RST : (inc ? count_r[i] + 8'h01 : count_r[i]));
    // Control write keeps the count; only the scalers restart
    ebpt_ctrl_s ctrl_nxt;
    assign ctrl_nxt = wr_ctrl ? ebpt_ctrl_s'(w_data_r[7:0] & `EBPT_CTRL_WMASK) : ctrl_r[i];
    assign post_done[i] = match_evt & post_hit & ~scal_clr;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pre_r <= 4'h0;
      end else begin
        pre_r <= pre_nxt;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        post_r <= 4'h0;
      end else begin
        post_r <= post_nxt;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        count_r[i] <= `EBPT_COUNT_RST;
      end else begin
        count_r[i] <= count_nxt;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        period_r[i] <= `EBPT_PERIOD_RST;
      end else if (wr_period) begin
        period_r[i] <= w_data_r[7:0];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_r[i] <= ebpt_ctrl_s'(`EBPT_CTRL_RST);
      end else begin
        ctrl_r[i] <= ctrl_nxt;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        match_r[i] <= 1'b0;
      end else begin
        match_r[i] <= match_evt;
      end
    end
  end

  // Read channel: one word in flight, answered the cycle after address
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_hs = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
  wire arready_nxt = ~rvalid_nxt;
  ebpt_sel_s rsel;
  assign rsel = reg_decode(s_axi_araddr);
  wire [1:0] ru = rsel.unit;
  wire [7:0] rd_ctrl = {1'b0, ctrl_r[ru][6:0]};
  wire [7:0] rd_byte = (rsel.kind == EBPT_REG_CTRL) ? rd_ctrl :
                       (rsel.kind == EBPT_REG_COUNT) ? count_r[ru] :
                       (rsel.kind == EBPT_REG_PERIOD) ? period_r[ru] :
                       (rsel.kind == EBPT_REG_IRQ_STATUS) ? 8'(irq_status_r) :
                       (rsel.kind == EBPT_REG_IRQ_ENABLE) ? 8'(irq_enable_r) : 8'h00;
  wire [1:0] rresp_nxt = (rsel.kind == EBPT_REG_NONE) ? `EBPT_RESP_SLVERR : `EBPT_RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= arready_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  // Captured at the address handshake so the word stands while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= 32'h0;
      rresp_r <= `EBPT_RESP_OKAY;
    end else if (ar_hs) begin
      rdata_r <= {24'h0, rd_byte};
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;
  // Same flop feeds both: the gate pulse is the PWM match, never a baud clock
  assign pwm_time_base_match = match_r;
  assign gate_match_pulse = match_r;

endmodule // ebpt_timer

// ==== ebpt_timer_chk.sv ====
// Purpose: Port-level assertions for the period timer block
// Assumes: One aclk domain, aresetn synchronous active low
// Notes: Bound to every ebpt_timer instance
`timescale 1ns/10ps
module ebpt_timer_chk #(
  parameter int NUM_TIMERS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_TIMERS-1:0] pwm_time_base_match,
  input wire logic [NUM_TIMERS-1:0] gate_match_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("second write taken too early");
  rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rresp[0])
    else $error("read word malformed");
  gate_same_a: assert property (gate_match_pulse == pwm_time_base_match)
    else $error("gate pulse differs from time base");
  pulse_gap_a: assert property (pwm_time_base_match[0] |=> !pwm_time_base_match[0] [*3])
    else $error("match pulses too close");
endmodule // ebpt_timer_chk

bind ebpt_timer ebpt_timer_chk #(.NUM_TIMERS(NUM_TIMERS)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwm_time_base_match(pwm_time_base_match), .gate_match_pulse(gate_match_pulse));

// ==== ebpt_pwm_sink.sv ====
// Purpose: Model of the PWM and gate consumers of the match outputs
// Assumes: Strobes are one aclk wide
// Notes: Counts only periods where both strobes agree
`timescale 1ns/10ps
module ebpt_pwm_sink #(
  parameter int NUM_TIMERS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_TIMERS-1:0] time_base,
  input wire logic [NUM_TIMERS-1:0] gate_pulse,
  output logic [NUM_TIMERS-1:0][7:0] seen
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        seen[i] <= seen[i] + 8'(time_base[i] & gate_pulse[i]);
      end
    end
  end
endmodule // ebpt_pwm_sink

// ==== tb_eight_bit_period_timer.sv ====
// Purpose: Self-checking bench for the period timer block
// Assumes: AXI4-Lite master tasks, byte address four times the index
// Notes: Byte strobes and protection are tied off
`include "ebpt_defs.svh"
`timescale 1ns/10ps
module tb_eight_bit_period_timer;
  import ebpt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrd, bv, arr, rv, irq;
  logic [1:0] bres, rres;
  logic [31:0] rdat;
  logic [2:0] pwm, gate;
  logic [2:0][7:0] seen;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  localparam logic [11:0] CI [3] = '{`EBPT_IDX_CTRL4, `EBPT_IDX_CTRL6, `EBPT_IDX_CTRL8};
  localparam int PS [3] = '{0, 1, 15};

  initial forever #10 aclk = ~aclk;
  ebpt_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq(irq), .pwm_time_base_match(pwm), .gate_match_pulse(gate));
  ebpt_pwm_sink sink (.aclk(aclk), .aresetn(aresetn), .time_base(pwm), .gate_pulse(gate), .seen(seen));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awa <= {i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) begin
        done = 1'b1;
        br <= 1'b0;
        chk(bres, er);
      end
    end
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] ev, input logic [1:0] er = 2'h0);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        done = 1'b1;
        rr <= 1'b0;
        chk(rdat, ev);
        chk(rres, er);
      end
    end
  endtask

  // Spacing of two steady match strobes, free of the restart after a write
  task automatic gap(input int u, input int exp);
    int k;
    k = 1;
    // Skip a strobe launched under the old setting
    repeat (2) @(posedge aclk);
    while (!pwm[u]) @(posedge aclk);
    @(posedge aclk);
    while (!pwm[u]) begin
      @(posedge aclk);
      k++;
    end
    chk(k, exp);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (25000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int u = 0; u < 3; u++) begin
      rd(`EBPT_IDX_COUNT4 + 12'(u), 32'h0);
      rd(`EBPT_IDX_PERIOD4 + 12'(u), 32'hff);
      rd(CI[u], 32'h0);
      wr(CI[u], 8'hfb);
      rd(CI[u], 32'h7b);
      wr(`EBPT_IDX_PERIOD4 + 12'(u), 8'h5a);
      rd(`EBPT_IDX_PERIOD4 + 12'(u), 32'h5a);
    end
    rd(12'h00f, 32'h0, `EBPT_RESP_SLVERR);
    wr(12'h00f, 8'h01, `EBPT_RESP_SLVERR);
    $display("register test done");
    for (int u = 0; u < 3; u++) begin
      wr(`EBPT_IDX_PERIOD4 + 12'(u), 8'h03);
      for (int c = 0; c < 4; c++) begin
        wr(CI[u], 8'h04 | 8'(c));
        gap(u, 16 << (2 * (c > 1 ? 2 : c)));
      end
      wr(CI[u], 8'h00);
      chk(32'(seen[u] != 8'h0), 32'h1);
    end
    $display("prescale test done");
    wr(`EBPT_IDX_IRQ_ENABLE, 8'h07);
    foreach (PS[j]) begin
      n = PS[j];
      wr(`EBPT_IDX_IRQ_CLEAR, 8'h07);
      rd(`EBPT_IDX_IRQ_STATUS, 32'h0);
      wr(`EBPT_IDX_COUNT6, 8'h00);
      wr(CI[1], {1'b0, 4'(n), 3'b100});
      while (!irq) begin
        @(posedge aclk);
        if (pwm[1]) n--;
      end
      chk(n, -1);
      wr(CI[1], 8'h00);
    end
    rd(`EBPT_IDX_IRQ_STATUS, 32'h2);
    wr(`EBPT_IDX_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(`EBPT_IDX_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`EBPT_IDX_IRQ_CLEAR, 8'h02);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    $display("interrupt test done");
    wr(`EBPT_IDX_COUNT8, 8'h21);
    wr(CI[2], 8'h78);
    rd(`EBPT_IDX_COUNT8, 32'h21);
    repeat (100) @(posedge aclk);
    rd(`EBPT_IDX_COUNT8, 32'h21);
    $display("hold test done");
    wrap_up();
  end
endmodule // tb_eight_bit_period_timer
